// [design/call_exec_cfg.svh]
`ifndef CALL_EXEC_CFG_SVH
`define CALL_EXEC_CFG_SVH

// State counts per instruction
`define STATES_CALL_PAIR    5'h11
`define STATES_CALL_FIXED   5'h0d
`define STATES_CALL_TABLE   5'h10
`define STATES_TRAP         5'h10
`define STATES_EXIT         5'h0a
`define STATES_EXIT_BYPASS  5'h0a
`define STATES_EXIT_INTR    5'h0d
`define STATES_BIT_TEST     5'h0a
`define STATES_FLAG_SKIP    5'h08
`define STATES_REQ_SKIP     5'h08

// Targets and table placement
`define TRAP_VECTOR         16'h0060
`define TABLE_BASE          8'h80
`define FIXED_AREA_TOP      5'h01

// Bit position of the skip flag inside the status word
`define SW_SKIP_BIT         5

// Flag select codes
`define FLAG_CODE_CARRY     3'h2
`define FLAG_CODE_HALF      3'h3
`define FLAG_CODE_ZERO      3'h4

// Request and test flag select ranges
`define REQ_NMI_INDEX       5'h00
`define REQ_LOW_LAST        5'h0c
`define REQ_HIGH_FIRST      5'h10
`define REQ_HIGH_LAST       5'h14

`endif

// [design/call_exec_pkg.sv]
package call_exec_pkg;

	typedef enum logic [3:0] {
		op_call_via_pair            = 4'h0,
		op_call_fixed_area          = 4'h1,
		op_call_table_vector        = 4'h2,
		op_software_trap            = 4'h3,
		op_subroutine_exit          = 4'h4,
		op_subroutine_exit_bypass   = 4'h5,
		op_interrupt_exit           = 4'h6,
		op_bit_test                 = 4'h7,
		op_bypass_if_flag_set       = 4'h8,
		op_bypass_if_flag_clear     = 4'h9,
		op_bypass_if_request_set    = 4'ha,
		op_bypass_if_request_clear  = 4'hb
	} op_type;

	typedef enum logic [2:0] {
		st_idle   = 3'h1,
		st_access = 3'h2,
		st_hold   = 3'h4
	} state_type;

	typedef logic [4:0] state_count_type;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic        last;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [1:0]  slot;
	} access_type;

	typedef struct packed {
		state_type       fsm;
		op_type          op;
		logic            idle;
		logic [1:0]      step;
		logic            rd_issue;
		logic [1:0]      rd_issue_slot;
		logic            rd_take;
		logic [1:0]      rd_take_slot;
		logic [2:0][7:0] rbuf;
		logic [10:0]     operand;
		logic [15:0]     ret_addr;
		logic [15:0]     sp;
		logic [15:0]     pair;
		logic [7:0]      page;
		logic [7:0]      sw;
		logic            mem_we;
		logic            mem_re;
		logic [15:0]     mem_addr;
		logic [7:0]      mem_wdata;
		logic            done;
		logic            pc_load;
		logic [15:0]     pc_value;
		logic            sp_load;
		logic [15:0]     sp_value;
		logic            sw_load;
		logic [7:0]      sw_value;
		logic            skip;
		logic            req_clear;
		logic [4:0]      req_index;
	} exec_state_type;

	typedef struct packed {
		state_count_type rem;
	} countdown_state_type;

endpackage : call_exec_pkg

// [design/state_countdown.sv]
`timescale 1ns/10ps
module state_countdown (
	// Clock and reset
	input  wire logic                            core_clk,
	input  wire logic                            rst_n,
	// Load and expiry
	input  wire logic                            load,
	input  wire call_exec_pkg::state_count_type  load_value,
	output logic                                 last
);

	call_exec_pkg::countdown_state_type q;
	call_exec_pkg::countdown_state_type next_q;

	always_comb begin
		next_q = q;
		if (load) begin
			next_q.rem = load_value;
		end else if (q.rem != 5'h00) begin
			next_q.rem = q.rem - 5'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// High in the final state of a run
	assign last = (q.rem == 5'h01);

endmodule : state_countdown

// [design/call_return_skip_exec.sv]
// What this block does
// - Pair call: push return, jump BC, 17
// - Fixed call: push, target 00001 plus offset, 13
// - Table call: push, target from table, 16
// - Trap: push status and return, 0060H, 16
// - Trap runs even when skip pending
// - Exit: pop return address, 10 states
// - Bypass exit also sets skip flag
// - Interrupt exit pops status too, 13
// - Bit test on working page, 10 states
// - Flag skip on carry/half/zero, 8 states
// - Request skip if set, clear except NMI
// - Request skip if clear, clear set flag except NMI
// - Trap ignores maskable interrupt enable
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "call_exec_cfg.svh"
module call_return_skip_exec (
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	// Instruction issue from sequencer
	input  wire logic                    start,
	input  wire call_exec_pkg::op_type   op,
	input  wire logic [10:0]             operand,
	input  wire logic [15:0]             next_pc,
	input  wire logic [15:0]             sp,
	input  wire logic [15:0]             pair_bc,
	input  wire logic [7:0]              work_page,
	input  wire logic [7:0]              status_word,
	output logic                         busy,
	output logic                         done,
	// Condition and request flags
	input  wire logic                    carry_flag,
	input  wire logic                    half_carry_flag,
	input  wire logic                    zero_flag,
	input  wire logic [20:0]             request_flags,
	output logic                         req_clear,
	output logic [4:0]                   req_clear_index,
	// Skip flag shared with the rest of the core
	input  wire logic                    other_skip_set,
	input  wire logic                    other_skip_clear,
	output logic                         bypass_next_flag,
	// Results
	output logic                         pc_load,
	output logic [15:0]                  pc_value,
	output logic                         sp_load,
	output logic [15:0]                  sp_value,
	output logic                         status_load,
	output logic [7:0]                   status_value,
	// Stack and program memory
	output logic                         mem_we,
	output logic                         mem_re,
	output logic [15:0]                  mem_addr,
	output logic [7:0]                   mem_wdata,
	input  wire logic [7:0]              mem_rdata
);

	call_exec_pkg::exec_state_type   q;
	call_exec_pkg::exec_state_type   next_q;
	call_exec_pkg::access_type       acc;
	call_exec_pkg::state_count_type  timer_value;
	logic                            timer_load;
	logic                            timer_last;
	logic                            start_ok;

	function automatic call_exec_pkg::state_count_type state_count(input call_exec_pkg::op_type o);
		case (o)
			call_exec_pkg::op_call_via_pair:           state_count = `STATES_CALL_PAIR;
			call_exec_pkg::op_call_fixed_area:         state_count = `STATES_CALL_FIXED;
			call_exec_pkg::op_call_table_vector:       state_count = `STATES_CALL_TABLE;
			call_exec_pkg::op_software_trap:           state_count = `STATES_TRAP;
			call_exec_pkg::op_subroutine_exit:         state_count = `STATES_EXIT;
			call_exec_pkg::op_subroutine_exit_bypass:  state_count = `STATES_EXIT_BYPASS;
			call_exec_pkg::op_interrupt_exit:          state_count = `STATES_EXIT_INTR;
			call_exec_pkg::op_bit_test:                state_count = `STATES_BIT_TEST;
			call_exec_pkg::op_bypass_if_flag_set,
			call_exec_pkg::op_bypass_if_flag_clear:    state_count = `STATES_FLAG_SKIP;
			default:                                   state_count = `STATES_REQ_SKIP;
		endcase
	endfunction : state_count

	// Returns {valid, value}; an unused code never skips
	function automatic logic [1:0] flag_select(input logic [2:0] code, input logic cy, input logic hc,
		input logic z);
		case (code)
			`FLAG_CODE_CARRY: flag_select = {1'b1, cy};
			`FLAG_CODE_HALF:  flag_select = {1'b1, hc};
			`FLAG_CODE_ZERO:  flag_select = {1'b1, z};
			default:          flag_select = 2'h0;
		endcase
	endfunction : flag_select

	function automatic logic request_valid(input logic [4:0] idx);
		request_valid = (idx <= `REQ_LOW_LAST) || ((idx >= `REQ_HIGH_FIRST) && (idx <= `REQ_HIGH_LAST));
	endfunction : request_valid

	function automatic call_exec_pkg::access_type plan_access(input call_exec_pkg::exec_state_type s);
		call_exec_pkg::access_type a;
		a = '0;
		case (s.op)
			call_exec_pkg::op_call_via_pair,
			call_exec_pkg::op_call_fixed_area,
			call_exec_pkg::op_call_table_vector: begin
				a.valid = 1'b1;
				case (s.step)
					2'h0: begin
						a.we    = 1'b1;
						a.addr  = s.sp - 16'h0001;
						a.wdata = s.ret_addr[15:8];
					end
					2'h1: begin
						a.we    = 1'b1;
						a.addr  = s.sp - 16'h0002;
						a.wdata = s.ret_addr[7:0];
						a.last  = (s.op != call_exec_pkg::op_call_table_vector);
					end
					2'h2: begin
						a.addr = {8'h00, `TABLE_BASE + {2'h0, s.operand[4:0], 1'b0}};
					end
					default: begin
						a.addr = {8'h00, `TABLE_BASE + {2'h0, s.operand[4:0], 1'b1}};
						a.slot = 2'h1;
						a.last = 1'b1;
					end
				endcase
			end
			call_exec_pkg::op_software_trap: begin
				a.valid = 1'b1;
				a.we    = 1'b1;
				case (s.step)
					2'h0: begin
						a.addr  = s.sp - 16'h0001;
						a.wdata = s.sw;
					end
					2'h1: begin
						a.addr  = s.sp - 16'h0002;
						a.wdata = s.ret_addr[15:8];
					end
					default: begin
						a.addr  = s.sp - 16'h0003;
						a.wdata = s.ret_addr[7:0];
						a.last  = 1'b1;
					end
				endcase
			end
			call_exec_pkg::op_subroutine_exit,
			call_exec_pkg::op_subroutine_exit_bypass,
			call_exec_pkg::op_interrupt_exit: begin
				a.valid = 1'b1;
				a.addr  = s.sp + {14'h0000, s.step};
				a.slot  = s.step;
				a.last  = (s.step == ((s.op == call_exec_pkg::op_interrupt_exit) ? 2'h2 : 2'h1));
			end
			call_exec_pkg::op_bit_test: begin
				a.valid = 1'b1;
				a.addr  = {s.page, s.operand[7:0]};
				a.last  = 1'b1;
			end
			default: begin
				a.last = 1'b1;
			end
		endcase
		return a;
	endfunction : plan_access

	assign start_ok = start && (q.fsm == call_exec_pkg::st_idle);
	assign acc      = plan_access(q);

	always_comb begin
		logic [1:0] fsel;
		logic       rset;
		fsel = flag_select(q.operand[2:0], carry_flag, half_carry_flag, zero_flag);
		rset = request_valid(q.operand[4:0]) && request_flags[q.operand[4:0]];
		next_q = q;
		next_q.done      = 1'b0;
		next_q.pc_load   = 1'b0;
		next_q.sp_load   = 1'b0;
		next_q.sw_load   = 1'b0;
		next_q.req_clear = 1'b0;
		next_q.mem_we    = 1'b0;
		next_q.mem_re    = 1'b0;
		next_q.rd_issue  = 1'b0;
		next_q.rd_take      = q.rd_issue;
		next_q.rd_take_slot = q.rd_issue_slot;
		timer_load  = 1'b0;
		timer_value = '0;
		// Read data stand one cycle after the strobe
		if (q.rd_take) begin
			next_q.rbuf[q.rd_take_slot] = mem_rdata;
		end
		if (other_skip_clear) begin
			next_q.skip = 1'b0;
		end
		if (other_skip_set) begin
			next_q.skip = 1'b1;
		end
		case (q.fsm)
			call_exec_pkg::st_idle: begin
				// No interrupt enable is consulted, so a trap is always taken
				if (start) begin
					next_q.op       = op;
					next_q.operand  = operand;
					next_q.ret_addr = next_pc;
					next_q.sp       = sp;
					next_q.pair     = pair_bc;
					next_q.page     = work_page;
					next_q.sw       = status_word;
					next_q.sw[`SW_SKIP_BIT] = q.skip;
					next_q.step     = 2'h0;
					next_q.idle     = q.skip && (op != call_exec_pkg::op_software_trap);
					timer_load      = 1'b1;
					timer_value     = state_count(op) - 5'h01;
					next_q.fsm      = next_q.idle ? call_exec_pkg::st_hold : call_exec_pkg::st_access;
				end
			end
			call_exec_pkg::st_access: begin
				if (acc.valid) begin
					next_q.mem_we        = acc.we;
					next_q.mem_re        = !acc.we;
					next_q.mem_addr      = acc.addr;
					next_q.mem_wdata     = acc.wdata;
					next_q.rd_issue      = !acc.we;
					next_q.rd_issue_slot = acc.slot;
				end
				next_q.step = q.step + 2'h1;
				if (acc.last) begin
					next_q.fsm = call_exec_pkg::st_hold;
				end
			end
			call_exec_pkg::st_hold: begin
				if (timer_last) begin
					next_q.fsm  = call_exec_pkg::st_idle;
					next_q.done = 1'b1;
					next_q.skip = 1'b0;
					if (!q.idle) begin
						case (q.op)
							call_exec_pkg::op_call_via_pair: begin
								next_q.pc_load  = 1'b1;
								next_q.pc_value = q.pair;
								next_q.sp_load  = 1'b1;
								next_q.sp_value = q.sp - 16'h0002;
							end
							call_exec_pkg::op_call_fixed_area: begin
								next_q.pc_load  = 1'b1;
								next_q.pc_value = {`FIXED_AREA_TOP, q.operand};
								next_q.sp_load  = 1'b1;
								next_q.sp_value = q.sp - 16'h0002;
							end
							call_exec_pkg::op_call_table_vector: begin
								next_q.pc_load  = 1'b1;
								next_q.pc_value = {q.rbuf[1], q.rbuf[0]};
								next_q.sp_load  = 1'b1;
								next_q.sp_value = q.sp - 16'h0002;
							end
							call_exec_pkg::op_software_trap: begin
								next_q.pc_load  = 1'b1;
								next_q.pc_value = `TRAP_VECTOR;
								next_q.sp_load  = 1'b1;
								next_q.sp_value = q.sp - 16'h0003;
							end
							call_exec_pkg::op_subroutine_exit,
							call_exec_pkg::op_subroutine_exit_bypass: begin
								next_q.pc_load  = 1'b1;
								next_q.pc_value = {q.rbuf[1], q.rbuf[0]};
								next_q.sp_load  = 1'b1;
								next_q.sp_value = q.sp + 16'h0002;
								next_q.skip     = (q.op == call_exec_pkg::op_subroutine_exit_bypass);
							end
							call_exec_pkg::op_interrupt_exit: begin
								next_q.pc_load  = 1'b1;
								next_q.pc_value = {q.rbuf[1], q.rbuf[0]};
								next_q.sp_load  = 1'b1;
								next_q.sp_value = q.sp + 16'h0003;
								next_q.sw_load  = 1'b1;
								next_q.sw_value = q.rbuf[2];
								next_q.skip     = q.rbuf[2][`SW_SKIP_BIT];
							end
							call_exec_pkg::op_bit_test: begin
								next_q.skip = q.rbuf[0][q.operand[10:8]];
							end
							call_exec_pkg::op_bypass_if_flag_set: begin
								next_q.skip = fsel[1] && fsel[0];
							end
							call_exec_pkg::op_bypass_if_flag_clear: begin
								next_q.skip = fsel[1] && !fsel[0];
							end
							call_exec_pkg::op_bypass_if_request_set: begin
								next_q.skip      = rset;
								next_q.req_clear = rset && (q.operand[4:0] != `REQ_NMI_INDEX);
								next_q.req_index = q.operand[4:0];
							end
							default: begin
								next_q.skip      = request_valid(q.operand[4:0]) && !rset;
								next_q.req_clear = rset && (q.operand[4:0] != `REQ_NMI_INDEX);
								next_q.req_index = q.operand[4:0];
							end
						endcase
					end
				end
			end
			default: begin
				next_q.fsm = call_exec_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q     <= '0;
			q.fsm <= call_exec_pkg::st_idle;
		end else begin
			q <= next_q;
		end
	end

	state_countdown u_countdown (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.load       (timer_load),
		.load_value (timer_value),
		.last       (timer_last)
	);

	assign busy             = (q.fsm != call_exec_pkg::st_idle);
	assign done             = q.done;
	assign req_clear        = q.req_clear;
	assign req_clear_index  = q.req_index;
	assign bypass_next_flag = q.skip;
	assign pc_load          = q.pc_load;
	assign pc_value         = q.pc_value;
	assign sp_load          = q.sp_load;
	assign sp_value         = q.sp_value;
	assign status_load      = q.sw_load;
	assign status_value     = q.sw_value;
	assign mem_we           = q.mem_we;
	assign mem_re           = q.mem_re;
	assign mem_addr         = q.mem_addr;
	assign mem_wdata        = q.mem_wdata;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_pair_timing: assert property (start_ok && op == call_exec_pkg::op_call_via_pair |-> ##17 done)
		else $error("pair call did not finish in its state count");
	a_fixed_target: assert property (done && pc_load && q.op == call_exec_pkg::op_call_fixed_area |-> pc_value[15:11] == `FIXED_AREA_TOP)
		else $error("fixed area call target has wrong upper bits");
	a_trap_vector: assert property (done && pc_load && q.op == call_exec_pkg::op_software_trap |-> pc_value == `TRAP_VECTOR)
		else $error("trap jumped to wrong address");
	a_trap_always: assert property (start_ok && op == call_exec_pkg::op_software_trap |-> ##16 (done && pc_load))
		else $error("trap was suppressed or late");
	a_exit_stack: assert property (done && sp_load && q.op == call_exec_pkg::op_subroutine_exit |-> sp_value == q.sp + 16'h0002)
		else $error("exit left wrong stack pointer");
	a_nmi_kept: assert property (req_clear |-> req_clear_index != `REQ_NMI_INDEX)
		else $error("non-maskable flag was cleared");
	a_idle_silent: assert property (busy && q.idle |-> !mem_we && !mem_re && !pc_load)
		else $error("skipped instruction touched memory or program counter");

	c_trap_over_skip: cover property (start_ok && op == call_exec_pkg::op_software_trap && q.skip);
	c_idle_done: cover property (done && q.idle);
	c_request_clear: cover property (req_clear);

endmodule : call_return_skip_exec

// [bench/stack_mem_model.sv]
`timescale 1ns/10ps
module stack_mem_model (
	// Clock
	input  wire logic        core_clk,
	// Memory bus from the core
	input  wire logic        mem_we,
	input  wire logic        mem_re,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic [7:0]       mem_rdata
);
	logic [7:0] mem [0:65535];
	int         writes;
	int         reads;
	initial begin
		writes = 0;
		reads = 0;
		mem_rdata = 8'h00;
	end
	// Data stand only in the cycle after a read; a toggling pattern exposes late sampling
	always @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
			writes <= writes + 1;
		end
		if (mem_re) begin
			mem_rdata <= mem[mem_addr];
			reads <= reads + 1;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : stack_mem_model

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic                  core_clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  start = 1'b0;
	call_exec_pkg::op_type op = call_exec_pkg::op_call_via_pair;
	logic [10:0]           operand = 11'h000;
	logic [15:0]           next_pc = 16'h0000;
	logic [15:0]           sp = 16'h0000;
	logic [15:0]           pair_bc = 16'h0000;
	logic [7:0]            work_page = 8'h00;
	logic [7:0]            status_word = 8'h00;
	logic                  carry_flag = 1'b0;
	logic                  half_carry_flag = 1'b0;
	logic                  zero_flag = 1'b0;
	logic [20:0]           request_flags = 21'h000000;
	logic                  other_skip_set = 1'b0;
	logic                  other_skip_clear = 1'b0;
	logic                  busy, done, req_clear, bypass_next_flag;
	logic [4:0]            req_clear_index;
	logic                  pc_load, sp_load, status_load, mem_we, mem_re;
	logic [15:0]           pc_value, sp_value, mem_addr;
	logic [7:0]            status_value, mem_wdata, mem_rdata;
	logic                  got_pc, got_clr, got_flag;
	logic [4:0]            got_idx;
	int                    failures = 0;
	int                    samples_checked = 0;
	int                    cycles = 0;

	always #12.5 core_clk = ~core_clk;

	call_return_skip_exec u_call_return_skip_exec (
		.core_clk(core_clk), .rst_n(rst_n), .start(start), .op(op), .operand(operand),
		.next_pc(next_pc), .sp(sp), .pair_bc(pair_bc), .work_page(work_page),
		.status_word(status_word), .busy(busy), .done(done), .carry_flag(carry_flag),
		.half_carry_flag(half_carry_flag), .zero_flag(zero_flag), .request_flags(request_flags),
		.req_clear(req_clear), .req_clear_index(req_clear_index), .other_skip_set(other_skip_set),
		.other_skip_clear(other_skip_clear), .bypass_next_flag(bypass_next_flag),
		.pc_load(pc_load), .pc_value(pc_value), .sp_load(sp_load), .sp_value(sp_value),
		.status_load(status_load), .status_value(status_value), .mem_we(mem_we),
		.mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	stack_mem_model u_stack_mem_model (
		.core_clk(core_clk), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	task automatic end_of_test;
		if (failures == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Whole run needs under a thousand cycles; the ceiling leaves ample margin
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	// Issues one instruction, counts cycles to done, then samples the skip flag one cycle later
	task automatic issue(input call_exec_pkg::op_type o, input logic [10:0] opd, input int n_exp);
		int n;
		@(posedge core_clk);
		op <= o;
		operand <= opd;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		n = 1;
		got_clr = 1'b0;
		got_idx = 5'h00;
		#1;
		while (done !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
			if (req_clear === 1'b1) begin
				got_clr = 1'b1;
				got_idx = req_clear_index;
			end
		end
		got_pc = pc_load;
		chk_val(16'(n), 16'(n_exp));
		@(posedge core_clk);
		#1;
		got_flag = bypass_next_flag;
	endtask : issue

	task automatic skip_pulse(input logic s);
		@(posedge core_clk);
		other_skip_set <= s;
		other_skip_clear <= ~s;
		@(posedge core_clk);
		other_skip_set <= 1'b0;
		other_skip_clear <= 1'b0;
		@(posedge core_clk);
	endtask : skip_pulse

	task automatic t_calls;
		next_pc <= 16'h1235;
		sp <= 16'h2000;
		pair_bc <= 16'hbeef;
		issue(call_exec_pkg::op_call_via_pair, 11'h000, 17);
		chk_bit(got_pc, 1'b1);
		chk_val(pc_value, 16'hbeef);
		chk_val(sp_value, 16'h1ffe);
		chk_val({u_stack_mem_model.mem[16'h1fff], u_stack_mem_model.mem[16'h1ffe]}, 16'h1235);
		next_pc <= 16'h4321;
		sp <= 16'h3000;
		issue(call_exec_pkg::op_call_fixed_area, 11'h7a5, 13);
		chk_val(pc_value, 16'h0fa5);
		chk_val(sp_value, 16'h2ffe);
		chk_val({u_stack_mem_model.mem[16'h2fff], u_stack_mem_model.mem[16'h2ffe]}, 16'h4321);
		// Last entry of the jump table sits at the top of its window
		u_stack_mem_model.mem[190] = 8'h34;
		u_stack_mem_model.mem[191] = 8'h56;
		next_pc <= 16'h0102;
		issue(call_exec_pkg::op_call_table_vector, 11'h01f, 16);
		chk_val(pc_value, 16'h5634);
		chk_val(sp_value, 16'h2ffe);
		chk_val({u_stack_mem_model.mem[16'h2fff], u_stack_mem_model.mem[16'h2ffe]}, 16'h0102);
	endtask : t_calls

	task automatic t_trap;
		skip_pulse(1'b1);
		status_word <= 8'ha5;
		next_pc <= 16'h0501;
		sp <= 16'h4000;
		issue(call_exec_pkg::op_software_trap, 11'h000, 16);
		chk_bit(got_pc, 1'b1);
		chk_val(pc_value, 16'h0060);
		chk_val(sp_value, 16'h3ffd);
		chk_val({8'h00, u_stack_mem_model.mem[16'h3fff]}, 16'h00a5);
		chk_val({u_stack_mem_model.mem[16'h3ffe], u_stack_mem_model.mem[16'h3ffd]}, 16'h0501);
		skip_pulse(1'b0);
	endtask : t_trap

	task automatic t_exits;
		int w;
		u_stack_mem_model.mem[16'h5000] = 8'h78;
		u_stack_mem_model.mem[16'h5001] = 8'h9a;
		u_stack_mem_model.mem[16'h5002] = 8'h20;
		sp <= 16'h5000;
		issue(call_exec_pkg::op_subroutine_exit, 11'h000, 10);
		chk_val(pc_value, 16'h9a78);
		chk_val(sp_value, 16'h5002);
		chk_bit(got_flag, 1'b0);
		issue(call_exec_pkg::op_subroutine_exit_bypass, 11'h000, 10);
		chk_val(pc_value, 16'h9a78);
		chk_bit(got_flag, 1'b1);
		w = u_stack_mem_model.writes;
		issue(call_exec_pkg::op_call_via_pair, 11'h000, 17);
		chk_bit(got_pc, 1'b0);
		chk_val(16'(u_stack_mem_model.writes - w), 16'h0000);
		chk_bit(got_flag, 1'b0);
		issue(call_exec_pkg::op_interrupt_exit, 11'h000, 13);
		chk_val(pc_value, 16'h9a78);
		chk_val(sp_value, 16'h5003);
		chk_val({8'h00, status_value}, 16'h0020);
		chk_bit(got_flag, 1'b1);
		skip_pulse(1'b0);
	endtask : t_exits

	task automatic t_skips;
		logic [7:0] pat;
		logic [4:0] codes [5];
		logic       v;
		pat = 8'h5a;
		codes = '{5'h00, 5'h01, 5'h0c, 5'h10, 5'h14};
		work_page <= 8'h10;
		u_stack_mem_model.mem[16'h10f0] = pat;
		for (int b = 0; b < 8; b++) begin
			issue(call_exec_pkg::op_bit_test, {3'(b), 8'hf0}, 10);
			chk_bit(got_flag, pat[b]);
			skip_pulse(1'b0);
		end
		for (int k = 0; k < 12; k++) begin
			v = k[0];
			// Unselected flags carry the opposite value so a wrong select shows
			carry_flag <= (k / 4 == 0) ? v : ~v;
			half_carry_flag <= (k / 4 == 1) ? v : ~v;
			zero_flag <= (k / 4 == 2) ? v : ~v;
			issue(k[1] ? call_exec_pkg::op_bypass_if_flag_clear : call_exec_pkg::op_bypass_if_flag_set,
				11'(k / 4 + 2), 8);
			chk_bit(got_flag, k[1] ? ~v : v);
			skip_pulse(1'b0);
		end
		for (int k = 0; k < 20; k++) begin
			v = k[0];
			request_flags <= v ? (21'h000001 << codes[k / 4]) : ~(21'h000001 << codes[k / 4]);
			issue(k[1] ? call_exec_pkg::op_bypass_if_request_clear : call_exec_pkg::op_bypass_if_request_set,
				{6'h00, codes[k / 4]}, 8);
			chk_bit(got_flag, k[1] ? ~v : v);
			chk_bit(got_clr, v & (codes[k / 4] != 5'h00));
			if (v && codes[k / 4] != 5'h00) begin
				chk_val({11'h000, got_idx}, {11'h000, codes[k / 4]});
			end
			skip_pulse(1'b0);
		end
	endtask : t_skips

	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_calls();
		t_trap();
		t_exits();
		t_skips();
		end_of_test();
	end
endmodule : tb_top
